// File: core/sdpd_pkg.sv
package sdpd_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 40000;
  localparam int CNT_W = 16;
  localparam int PD_EXIT_DLL_MIN_CK = 10;
  localparam int PD_EXIT_DLL_NS = 24;
  localparam int PD_EXIT_DLL_NS_CK = (PD_EXIT_DLL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PD_EXIT_DLL_CK =
    (PD_EXIT_DLL_NS_CK > PD_EXIT_DLL_MIN_CK) ? PD_EXIT_DLL_NS_CK : PD_EXIT_DLL_MIN_CK;
  localparam int ACT_TO_PD_CK = 1;
  localparam int PRE_TO_PD_CK = 1;
  localparam int REF_TO_PD_CK = 1;
  localparam int READ_PD_EXTRA_CK = 5;
  localparam int WRITE_PD_EXTRA_CK = 4;
  localparam int FIXED_CHOP_SAVING_CK = 2;
  localparam int WRITE_AP_EXTRA_CK = 1;
  localparam int REFRESH_PD_LIMIT = 9;
  localparam int PD_EXIT_LATENCY_CK = 3;
  localparam int BUFFER_DISABLE_DELAY_CK = 1;
  localparam int MIN_PD_TIME_CK = 3;
  localparam int MIN_CKE_PULSE_CK = 3;
  localparam int MODE_UPDATE_DELAY_CK = 12;
  localparam int ASYNC_TERM_LEAD_CK = 1;
  localparam int REFRESH_INTERVAL_CK = 195;
  // ----------------------------------------------------------------
  // mode register fields, bank count and command codes
  // ----------------------------------------------------------------
  localparam int MR2_AUTO_SELFREF_BIT = 6;
  localparam int MR2_SELFREF_TEMP_BIT = 7;
  localparam int MR0_WR_LSB = 9;
  localparam int MR0_WR_W = 3;
  localparam int MR0_PD_EXIT_BIT = 12;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_DES = 4'h8;

  typedef enum logic [2:0]
  {
    SR_NORMAL = 3'h1,
    SR_EXTENDED = 3'h2,
    SR_ILLEGAL = 3'h4
  } sdpd_sr_e;

  // timing settings from the user
  typedef struct packed
  {
    logic [4:0] read_latency;
    logic [4:0] write_latency;
    logic [4:0] write_recovery;
    logic fixed_burst_chop;
    logic pd_slow_exit;
  } sdpd_cfg_s;

  // one command seen on the bus
  typedef struct packed
  {
    logic valid;
    logic [3:0] code;
    logic [BANK_W-1:0] bank;
    logic autoprecharge;
    logic precharge_all;
  } sdpd_cmd_s;
endpackage : sdpd_pkg

// File: core/sdpd_bank_track.sv
`timescale 1ns/1ps
module sdpd_bank_track
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire sdpd_pkg::sdpd_cmd_s cmd,
  output logic any_open
);
  logic [sdpd_pkg::NUM_BANKS-1:0] open_reg;
  logic [sdpd_pkg::NUM_BANKS-1:0] open_next;

  // ----------------------------------------------------------------
  // per-bank open state
  // ----------------------------------------------------------------
  // bank open tracking
  always_comb
  begin
    open_next = open_reg;
    for (int i = 0; i < sdpd_pkg::NUM_BANKS; i++)
    begin
      if (cmd.valid && cmd.bank == i[sdpd_pkg::BANK_W-1:0])
      begin
        if (cmd.code == sdpd_pkg::CMD_ACT)
          open_next[i] = 1'b1;
        else if ((cmd.code == sdpd_pkg::CMD_RD || cmd.code == sdpd_pkg::CMD_WR)
                 && cmd.autoprecharge)
          open_next[i] = 1'b0;
      end
      if (cmd.valid && cmd.code == sdpd_pkg::CMD_PRE
          && (cmd.precharge_all || cmd.bank == i[sdpd_pkg::BANK_W-1:0]))
        open_next[i] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      open_reg <= '0;
    else if (ce)
      open_reg <= open_next;
  end

  assign any_open = |open_reg;
endmodule : sdpd_bank_track

// File: core/sdpd_counter.sv
`timescale 1ns/1ps
module sdpd_counter
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [sdpd_pkg::CNT_W-1:0] value,
  output logic done
);
  logic [sdpd_pkg::CNT_W-1:0] cnt_reg;
  logic [sdpd_pkg::CNT_W-1:0] cnt_next;

  // ----------------------------------------------------------------
  // down counter, done at zero
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_next = cnt_reg;
    if (load)
    begin
      if (value > cnt_reg)
        cnt_next = value;
      else if (cnt_reg != '0)
        cnt_next = cnt_reg - 1'b1;
    end
    else if (cnt_reg != '0)
      cnt_next = cnt_reg - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (ce)
      cnt_reg <= cnt_next;
  end

  assign done = (cnt_reg == '0);
endmodule : sdpd_counter

// File: core/sdpd_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - auto-selfref and temp-range bits select normal or extended; both set illegal
// - never drop clock enable during mode, mpr, calibration, read or write
// - wait one cycle after activate, precharge, refresh; mode delay after mode set
// - read: rl plus five; write: wl plus four plus recovery, chop minus two
// - write recovery field is recovery time over period, rounded up
// - only nop or deselect until buffer-disable delay has elapsed
// - dll unlocked at entry means dll reset needed after exit
// - hold clock enable low, reset high, clock and termination valid
// - hold power-down at least minimum time, at most nine refresh intervals; the code exits after pd_max_cycles instead
// - exit with clock enable high and nop; hold high minimum pulse
// - wait exit latency, or dll exit latency for reads after slow exit
// - exit-refresh-reentry: exit latency before refresh, dll latency before reentry
// - slow exit: termination asynchronous from lead before entry to after exit
module sdpd_ctrl
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire sdpd_pkg::sdpd_cfg_s cfg,
  input wire logic [sdpd_pkg::CNT_W-1:0] pd_max_cycles,
  input wire logic auto_selfref_enable,
  input wire logic selfref_temp_range,
  input wire logic mrs_busy,
  input wire logic dll_locked,
  input wire logic pd_req,
  input wire sdpd_pkg::sdpd_cmd_s user_cmd,
  output logic user_cmd_ready,
  output logic user_read_ready,
  output logic pd_active,
  output logic dll_reset_needed,
  output sdpd_pkg::sdpd_sr_e selfref_mode,
  output logic mode_illegal,
  output logic term_async,
  output logic mem_cke,
  output logic mem_reset_n,
  output sdpd_pkg::sdpd_cmd_s mem_cmd
);
  typedef enum logic [4:0]
  {
    ST_RUN = 5'h01,
    ST_LEAD = 5'h02,
    ST_PD = 5'h04,
    ST_EXIT = 5'h08,
    ST_SETTLE = 5'h10
  } sdpd_state_e;

  sdpd_state_e state_reg;
  sdpd_state_e state_next;
  logic cke_reg;
  logic cke_next;
  logic async_reg;
  logic async_next;
  logic slow_reg;
  logic slow_next;
  logic dllrst_reg;
  logic dllrst_next;
  logic [sdpd_pkg::CNT_W-1:0] stay_reg;
  logic [sdpd_pkg::CNT_W-1:0] stay_next;
  sdpd_pkg::sdpd_cmd_s cmd_reg;
  sdpd_pkg::sdpd_cmd_s cmd_next;
  logic any_open;
  logic cmd_issue;
  logic entry_ok;
  logic exit_ok;
  logic dll_ok;
  logic pdmin_ok;
  logic pulse_ok;
  logic buf_ok;
  logic lead_ok;
  logic entry_load;
  logic exit_load;
  logic dll_load;
  logic [sdpd_pkg::CNT_W-1:0] entry_val;
  logic [sdpd_pkg::CNT_W-1:0] exit_val;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [sdpd_pkg::CNT_W-1:0] to_cnt(input int v);
    return v[sdpd_pkg::CNT_W-1:0];
  endfunction : to_cnt

  function automatic logic is_quiet(input sdpd_pkg::sdpd_cmd_s c);
    return !c.valid || c.code == sdpd_pkg::CMD_NOP || c.code == sdpd_pkg::CMD_DES;
  endfunction : is_quiet

  // ----------------------------------------------------------------
  // self refresh temperature mode
  // ----------------------------------------------------------------
  // range decode
  always_comb
  begin
    unique case ({auto_selfref_enable, selfref_temp_range})
      2'b00: selfref_mode = sdpd_pkg::SR_NORMAL;
      2'b11: selfref_mode = sdpd_pkg::SR_ILLEGAL;
      default: selfref_mode = sdpd_pkg::SR_EXTENDED;
    endcase
  end
  assign mode_illegal = auto_selfref_enable & selfref_temp_range;

  // ----------------------------------------------------------------
  // entry delay since last command
  // ----------------------------------------------------------------
  assign cmd_issue = user_cmd.valid && user_cmd_ready && !is_quiet(user_cmd);

  always_comb
  begin
    entry_val = '0;
    unique case (user_cmd.code)
      sdpd_pkg::CMD_ACT: entry_val = to_cnt(sdpd_pkg::ACT_TO_PD_CK);
      sdpd_pkg::CMD_PRE: entry_val = to_cnt(sdpd_pkg::PRE_TO_PD_CK);
      sdpd_pkg::CMD_REF: entry_val = to_cnt(sdpd_pkg::REF_TO_PD_CK);
      sdpd_pkg::CMD_MRS: entry_val = to_cnt(sdpd_pkg::MODE_UPDATE_DELAY_CK);
      sdpd_pkg::CMD_RD:
        entry_val = to_cnt(sdpd_pkg::READ_PD_EXTRA_CK) + to_cnt(int'(cfg.read_latency));
      sdpd_pkg::CMD_WR:
      begin
        entry_val = to_cnt(int'(cfg.write_latency)) + to_cnt(int'(cfg.write_recovery))
                    + to_cnt(sdpd_pkg::WRITE_PD_EXTRA_CK);
        if (cfg.fixed_burst_chop)
          entry_val = entry_val - to_cnt(sdpd_pkg::FIXED_CHOP_SAVING_CK);
        if (user_cmd.autoprecharge)
          entry_val = entry_val + to_cnt(sdpd_pkg::WRITE_AP_EXTRA_CK);
      end
      default: entry_val = '0;
    endcase
  end
  assign entry_load = cmd_issue;

  sdpd_counter u_entry
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(entry_load),
    .value(entry_val),
    .done(entry_ok)
  );

  sdpd_bank_track u_banks
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cmd(mem_cmd),
    .any_open(any_open)
  );

  // ----------------------------------------------------------------
  // power-down timers
  // ----------------------------------------------------------------
  assign exit_load = (state_reg == ST_PD) && state_next == ST_EXIT
                     || (state_reg == ST_RUN && state_next == ST_LEAD)
                     || (state_reg == ST_LEAD && state_next == ST_PD);
  always_comb
  begin
    exit_val = '0;
    if (state_reg == ST_RUN)
      exit_val = to_cnt(sdpd_pkg::ASYNC_TERM_LEAD_CK);
    else if (state_reg == ST_LEAD)
      exit_val = to_cnt(sdpd_pkg::MIN_PD_TIME_CK);
    else
      exit_val = to_cnt(sdpd_pkg::MIN_CKE_PULSE_CK);
  end

  sdpd_counter u_pulse
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(exit_load),
    .value(exit_val),
    .done(pulse_ok)
  );
  assign pdmin_ok = pulse_ok;
  assign lead_ok = pulse_ok;

  // dll exit latency also gates reentry
  assign dll_load = (state_reg == ST_PD) && state_next == ST_EXIT;
  sdpd_counter u_dll
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(dll_load),
    .value(to_cnt(sdpd_pkg::PD_EXIT_DLL_CK + sdpd_pkg::ASYNC_TERM_LEAD_CK)),
    .done(dll_ok)
  );

  sdpd_counter u_exit
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(dll_load),
    .value(to_cnt(sdpd_pkg::PD_EXIT_LATENCY_CK)),
    .done(exit_ok)
  );

  sdpd_counter u_buf
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(state_reg == ST_LEAD && state_next == ST_PD),
    .value(to_cnt(sdpd_pkg::BUFFER_DISABLE_DELAY_CK)),
    .done(buf_ok)
  );

  // ----------------------------------------------------------------
  // power-down state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    cke_next = cke_reg;
    async_next = async_reg;
    slow_next = slow_reg;
    dllrst_next = dllrst_reg;
    stay_next = stay_reg;
    unique case (state_reg)
      ST_RUN:
      begin
        if (pd_req && entry_ok && dll_ok && !mrs_busy && !cmd_issue)
        begin
          slow_next = !any_open && cfg.pd_slow_exit;
          async_next = !any_open && cfg.pd_slow_exit;
          dllrst_next = dllrst_reg | !dll_locked;
          state_next = ST_LEAD;
        end
      end
      ST_LEAD:
      begin
        if (lead_ok)
        begin
          cke_next = 1'b0;
          stay_next = '0;
          state_next = ST_PD;
        end
      end
      ST_PD:
      begin
        stay_next = stay_reg + 1'b1;
        if (pdmin_ok && buf_ok && (!pd_req || stay_reg >= pd_max_cycles))
        begin
          cke_next = 1'b1;
          state_next = ST_EXIT;
        end
      end
      ST_EXIT:
      begin
        if (pulse_ok && exit_ok)
          state_next = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        if (dll_ok || !slow_reg)
        begin
          async_next = 1'b0;
          slow_next = 1'b0;
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
    // dll reset request cleared by mode set
    if (cmd_issue && user_cmd.code == sdpd_pkg::CMD_MRS && state_reg == ST_RUN)
      dllrst_next = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_RUN;
      cke_reg <= 1'b1;
      async_reg <= 1'b0;
      slow_reg <= 1'b0;
      dllrst_reg <= 1'b0;
      stay_reg <= '0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      cke_reg <= cke_next;
      async_reg <= async_next;
      slow_reg <= slow_next;
      dllrst_reg <= dllrst_next;
      stay_reg <= stay_next;
    end
  end

  // ----------------------------------------------------------------
  // command path
  // ----------------------------------------------------------------
  // commands only in run state
  assign user_cmd_ready = (state_reg == ST_RUN) && !pd_req && ce;
  assign user_read_ready = user_cmd_ready && !dllrst_reg;

  always_comb
  begin
    cmd_next = '0;
    cmd_next.code = sdpd_pkg::CMD_NOP;
    if (cmd_issue)
      cmd_next = user_cmd;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_reg <= '0;
      cmd_reg.code <= sdpd_pkg::CMD_NOP;
    end
    else if (ce)
      cmd_reg <= cmd_next;
  end

  assign mem_cmd = cmd_reg;
  assign mem_cke = cke_reg;
  assign mem_reset_n = !rst;
  assign pd_active = (state_reg == ST_PD);
  assign term_async = async_reg;
  assign dll_reset_needed = dllrst_reg;
endmodule : sdpd_ctrl

// File: sim/sdpd_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// device side of the power-down pins
// ----------------------------------------
module sdpd_mem_model
(
  input wire logic clk,
  input wire logic mem_reset_n,
  input wire logic mem_cke,
  input wire sdpd_pkg::sdpd_cmd_s mem_cmd,
  input wire logic slow_exit,
  output logic in_pd,
  output logic active_pd,
  output logic dll_off,
  output logic bad_cmd
);
  logic [7:0] open_reg;
  logic cke_reg;
  logic quiet;
  assign quiet = mem_cmd.code == sdpd_pkg::CMD_NOP || mem_cmd.code == sdpd_pkg::CMD_DES;
  always @(posedge clk or negedge mem_reset_n)
  begin
    if (!mem_reset_n)
    begin
      {in_pd, active_pd, dll_off, bad_cmd, open_reg, cke_reg} <= {12'h0, 1'b1};
    end
    else
    begin
      cke_reg <= mem_cke;
      // bank work, inputs off in power-down
      if (!in_pd && mem_cmd.code == sdpd_pkg::CMD_ACT)
        open_reg[mem_cmd.bank] <= 1'b1;
      if (!in_pd && mem_cmd.code == sdpd_pkg::CMD_PRE)
        open_reg <= mem_cmd.precharge_all ? 8'h00 : open_reg & ~(8'h01 << mem_cmd.bank);
      if (cke_reg && !mem_cke && quiet)
      begin
        in_pd <= 1'b1;
        active_pd <= |open_reg;
        dll_off <= slow_exit && open_reg == 8'h00;
      end
      if (in_pd && mem_cke)
        {in_pd, dll_off} <= 2'h0;
      if ((!mem_cke || in_pd) && !quiet)
        bad_cmd <= 1'b1;
    end
  end
endmodule : sdpd_mem_model

// File: sim/sdpd_ctrl_assertions.sv
`timescale 1ns/1ps
module sdpd_ctrl_assertions
(
  input wire logic clk,
  input wire logic rst,
  input wire sdpd_pkg::sdpd_cfg_s cfg,
  input wire logic auto_selfref_enable,
  input wire logic selfref_temp_range,
  input wire sdpd_pkg::sdpd_sr_e selfref_mode,
  input wire logic mode_illegal,
  input wire logic term_async,
  input wire logic mem_cke,
  input wire logic mem_reset_n,
  input wire sdpd_pkg::sdpd_cmd_s mem_cmd
);
  // ----------------------------------------
  // cycles since read and write
  // ----------------------------------------
  logic [7:0] rd_gap_reg, rd_gap_next, wr_gap_reg, wr_gap_next;
  logic quiet;
  assign quiet = mem_cmd.code == sdpd_pkg::CMD_NOP || mem_cmd.code == sdpd_pkg::CMD_DES;
  always_comb
  begin
    rd_gap_next = (mem_cmd.code == sdpd_pkg::CMD_RD) ? 8'h01
      : rd_gap_reg + {7'h0, rd_gap_reg != 8'hff};
    wr_gap_next = (mem_cmd.code == sdpd_pkg::CMD_WR) ? 8'h01
      : wr_gap_reg + {7'h0, wr_gap_reg != 8'hff};
  end
  always_ff @(posedge clk)
  begin
    rd_gap_reg <= rst ? 8'hff : rd_gap_next;
    wr_gap_reg <= rst ? 8'hff : wr_gap_next;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence pd_hold;
    !mem_cke && quiet;
  endsequence
  sequence exit_hold;
    mem_cke && quiet;
  endsequence
  sequence no_read;
    mem_cmd.code != sdpd_pkg::CMD_RD;
  endsequence
  a_reset_pin_high: assert property (!rst |-> mem_reset_n)
    else $error("reset pin low outside reset");
  a_pd_entry_hold: assert property ($fell(mem_cke) |-> pd_hold [*3])
    else $error("power-down entry not held quiet");
  a_pd_exit_hold: assert property ($rose(mem_cke) |-> exit_hold [*3])
    else $error("power-down exit not held quiet");
  a_read_entry_gap: assert property ($fell(mem_cke) |->
    rd_gap_reg >= {3'h0, cfg.read_latency} + 8'h05)
    else $error("entry too soon after read");
  a_write_entry_gap: assert property ($fell(mem_cke) |-> wr_gap_reg >=
    {3'h0, cfg.write_latency} + 8'h04 + {3'h0, cfg.write_recovery}
    - {6'h0, cfg.fixed_burst_chop, 1'b0})
    else $error("entry too soon after write");
  a_term_async_lead: assert property ($fell(mem_cke) && term_async |-> $past(term_async))
    else $error("termination not async before entry");
  a_slow_exit_read: assert property ($rose(mem_cke) && term_async |-> no_read [*8])
    else $error("read too soon after slow exit");
  a_mode_illegal: assert property (auto_selfref_enable && selfref_temp_range |->
    mode_illegal && selfref_mode == sdpd_pkg::SR_ILLEGAL)
    else $error("both selfref bits not illegal");
  a_mode_extended: assert property (auto_selfref_enable ^ selfref_temp_range |->
    !mode_illegal && selfref_mode == sdpd_pkg::SR_EXTENDED)
    else $error("one selfref bit not extended");
endmodule : sdpd_ctrl_assertions
bind sdpd_ctrl sdpd_ctrl_assertions chk_u
(
  .clk(clk), .rst(rst), .cfg(cfg), .auto_selfref_enable(auto_selfref_enable),
  .selfref_temp_range(selfref_temp_range), .selfref_mode(selfref_mode),
  .mode_illegal(mode_illegal), .term_async(term_async), .mem_cke(mem_cke),
  .mem_reset_n(mem_reset_n), .mem_cmd(mem_cmd)
);

// File: sim/test_sdpd_ctrl.sv
`timescale 1ns/1ps
module test_sdpd_ctrl;
  logic clk, rst, ce, auto_selfref_enable, selfref_temp_range, mrs_busy, dll_locked, pd_req;
  logic user_cmd_ready, user_read_ready, pd_active, dll_reset_needed, mode_illegal, term_async;
  logic mem_cke, mem_reset_n, in_pd, active_pd, dll_off, bad_cmd;
  logic [sdpd_pkg::CNT_W-1:0] pd_max_cycles;
  logic [31:0] lfsr_state;
  logic [6:0] exp_q[$];
  sdpd_pkg::sdpd_cfg_s cfg;
  sdpd_pkg::sdpd_cmd_s user_cmd, mem_cmd;
  sdpd_pkg::sdpd_sr_e selfref_mode;
  int errors, check_count, n;
  sdpd_ctrl dut_u
  (
    .clk(clk), .rst(rst), .ce(ce), .cfg(cfg), .pd_max_cycles(pd_max_cycles),
    .auto_selfref_enable(auto_selfref_enable), .selfref_temp_range(selfref_temp_range),
    .mrs_busy(mrs_busy), .dll_locked(dll_locked), .pd_req(pd_req), .user_cmd(user_cmd),
    .user_cmd_ready(user_cmd_ready), .user_read_ready(user_read_ready), .pd_active(pd_active),
    .dll_reset_needed(dll_reset_needed), .selfref_mode(selfref_mode), .mode_illegal(mode_illegal),
    .term_async(term_async), .mem_cke(mem_cke), .mem_reset_n(mem_reset_n), .mem_cmd(mem_cmd)
  );
  sdpd_mem_model mem_u
  (
    .clk(clk), .mem_reset_n(mem_reset_n), .mem_cke(mem_cke), .mem_cmd(mem_cmd),
    .slow_exit(cfg.pd_slow_exit), .in_pd(in_pd), .active_pd(active_pd), .dll_off(dll_off),
    .bad_cmd(bad_cmd)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic wait_for(input string what, ref logic sig, input logic lvl);
    n = 0;
    @(posedge clk);
    while (sig !== lvl && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 300)
    begin
      check(what, 16'h0, 16'h1);
      conclude();
    end
  endtask : wait_for
  task automatic issue(input logic [3:0] code, input logic all);
    lfsr_state = lfsr_step(lfsr_state);
    ce <= lfsr_state[5];
    @(posedge clk);
    ce <= 1'b1;
    user_cmd <= '{1'b1, code, lfsr_state[2:0], 1'b0, all};
    exp_q.push_back({code, lfsr_state[2:0]});
    wait_for("cmd taken", user_cmd_ready, 1'b1);
    user_cmd.valid <= 1'b0;
    @(posedge clk);
  endtask : issue
  task automatic pd_cycle(input logic slow, input logic act);
    cfg.pd_slow_exit <= slow;
    pd_req <= 1'b1;
    wait_for("pd entry", mem_cke, 1'b0);
    repeat (8) @(posedge clk);
    check("pd kind", 16'({in_pd, active_pd, dll_off, term_async, mem_cke}),
      16'({1'b1, act, slow & !act, slow & !act, 1'b0}));
    pd_req <= 1'b0;
    wait_for("pd exit", mem_cke, 1'b1);
    wait_for("read ready", user_read_ready, 1'b1);
    check("exit wait", 16'(n + 2 >= ((slow && !act) ? 10 : 3)), 16'h1);
  endtask : pd_cycle
  // ----------------------------------------
  // monitor
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst && mem_cmd.code !== sdpd_pkg::CMD_NOP && mem_cmd.code !== sdpd_pkg::CMD_DES)
    begin
      if (exp_q.size() == 0)
        check("extra cmd", 16'(mem_cmd.code), 16'hffff);
      else
        check("cmd", 16'({mem_cmd.code, mem_cmd.bank}), 16'(exp_q.pop_front()));
    end
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    {rst, ce, auto_selfref_enable, selfref_temp_range, mrs_busy, dll_locked, pd_req} = 7'h62;
    cfg = '{5'h06, 5'h05, 5'h04, 1'b1, 1'b0};
    pd_max_cycles = 16'h0014;
    user_cmd = '0;
    lfsr_state = 32'h5627;
    errors = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    check("reset pins", 16'({mem_reset_n, mem_cke}), 16'h1);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      {auto_selfref_enable, selfref_temp_range} <= 2'(i);
      @(posedge clk);
      check("selfref", 16'({mode_illegal, selfref_mode}),
        (i == 3) ? 16'hc : 16'(i ? 2 : 1));
    end
    {auto_selfref_enable, selfref_temp_range} <= 2'h0;
    issue(sdpd_pkg::CMD_ACT, 1'b0);
    issue(sdpd_pkg::CMD_WR, 1'b0);
    issue(sdpd_pkg::CMD_RD, 1'b0);
    pd_cycle(1'b1, 1'b1);
    issue(sdpd_pkg::CMD_PRE, 1'b1);
    issue(sdpd_pkg::CMD_REF, 1'b0);
    pd_cycle(1'b0, 1'b0);
    pd_cycle(1'b1, 1'b0);
    mrs_busy <= 1'b1;
    pd_req <= 1'b1;
    repeat (30) @(posedge clk);
    check("busy blocks", 16'(mem_cke), 16'h1);
    mrs_busy <= 1'b0;
    wait_for("pd entry", mem_cke, 1'b0);
    wait_for("pd limit", mem_cke, 1'b1);
    check("pd stay", 16'(n >= 2 && n <= 22), 16'h1);
    dll_locked <= 1'b0;
    wait_for("reentry", mem_cke, 1'b0);
    check("reentry gap", 16'(n + 1 >= 10), 16'h1);
    pd_req <= 1'b0;
    wait_for("ready", user_cmd_ready, 1'b1);
    dll_locked <= 1'b1;
    repeat (12) @(posedge clk);
    check("dll reset", 16'({dll_reset_needed, user_read_ready}), 16'h2);
    issue(sdpd_pkg::CMD_MRS, 1'b0);
    check("dll cleared", 16'(dll_reset_needed), 16'h0);
    check("protocol", 16'(bad_cmd), 16'h0);
    pd_req <= 1'b1;
    wait_for("model pd", in_pd, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check("reset exit", 16'({in_pd, mem_reset_n, mem_cke}), 16'h1);
    {rst, pd_req} <= 2'h0;
    repeat (3) @(posedge clk);
    check("queue empty", 16'(exp_q.size()), 16'h0);
    conclude();
  end
endmodule : test_sdpd_ctrl
